// ==== core/lcr_pkg.sv ====
// package for the eight-channel line control register bank
package lcr_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets inside a channel, channel stride
  localparam logic [3:0] OFF_PATTERN = 4'h0;
  localparam logic [3:0] OFF_JA_CFG = 4'h1;
  localparam logic [3:0] OFF_TX_TEST_LOOP = 4'h2;
  localparam logic [3:0] OFF_CODING = 4'h3;
  localparam int CH_STRIDE = 16;
  // field positions
  localparam int POS_PATTERN_TYPE = 7;
  localparam int POS_PATH_LO = 2;
  localparam int POS_BW = 1;
  localparam int POS_DEPTH = 0;
  localparam int POS_INVERT = 7;
  localparam int POS_DIAG_LO = 4;
  localparam int POS_TX_EN = 3;
  localparam int POS_LOOP_LO = 0;
  localparam int POS_LINE_CODE = 5;
  localparam int POS_RES_LO = 3;
  localparam int POS_BPV = 2;
  // writable masks and reset values
  localparam logic [7:0] MASK_PATTERN = 8'h80;
  localparam logic [7:0] MASK_JA_CFG = 8'h0f;
  localparam logic [7:0] MASK_CODING = 8'h3c;
  localparam logic [7:0] RST_REG = 8'h00;
  // jitter corner in tenths of hertz, buffer depths in bits
  localparam logic [6:0] BW_E1_WIDE = 7'h64;
  localparam logic [6:0] BW_E1_NARROW = 7'h0f;
  localparam logic [6:0] BW_T1 = 7'h1e;
  localparam logic [6:0] DEPTH_SHORT = 7'h20;
  localparam logic [6:0] DEPTH_LONG = 7'h40;
  // resistor values in ohms
  localparam logic [7:0] RES_240 = 8'hf0;
  localparam logic [7:0] RES_210 = 8'hd2;
  localparam logic [7:0] RES_150 = 8'h96;
  localparam int FIFO_DEPTH = 8;
  typedef enum {lcr_pat_none, lcr_pat_qrss, lcr_pat_prbs, lcr_pat_ones} lcr_pattern_e;
  typedef enum {lcr_loop_none, lcr_loop_dual, lcr_loop_analog, lcr_loop_remote, lcr_loop_digital} lcr_loop_e;
  // per-channel decoded control word
  typedef struct packed {
    logic tx_power;
    logic pattern_invert;
    logic [1:0] pattern;
    logic [2:0] loop;
    logic ja_tx;
    logic ja_rx;
    logic [6:0] ja_corner;
    logic [6:0] ja_depth;
    logic [5:0] ja_latency;
    logic ami;
    logic [7:0] res_ohms;
  } lcr_ctrl_s;
  // violation event word carried through the buffer
  typedef struct packed {
    logic [2:0] channel;
  } lcr_event_s;
endpackage

// ==== core/lcr_regs.sv ====
// per-channel control registers, decode, violation insertion and event fifo
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - e1 corner 10 or 1.5 hz, t1 3 hz
// - buffer depth 32 or 64 bits
// - buffer latency is half the depth
// - invert bit flips quasi-random pattern polarity
// - pattern select none, quasi-random, all ones
// - transmitter on needs enable bit and pin
// - loopback select none, dual, analog, remote, digital
// - single rail zero-substitution or plain ami code
// - resistor select none, 240, 210, 150 ohms
// - rising violation bit inserts one violation
// - violation bit sampled on transmit clock
// - attenuator path none, transmit, receive
// - pattern type quasi-random or pseudo-random

// small synchronous fifo with valid and ready on both sides
module lcr_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write, no reset needed for data
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
  // pointers and fill count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // lcr_fifo

module lcr_regs
  import lcr_pkg::*;
#(
  parameter int NCH = lcr_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [lcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic e1_mode,
  input wire logic single_rail,
  input wire logic tx_power_pin,
  input wire logic [NCH-1:0] tx_line_clock,
  output lcr_pkg::lcr_ctrl_s [NCH-1:0] ch_ctrl,
  output logic [NCH-1:0] bpv_strobe,
  output logic [2:0] bpv_channel,
  output logic bpv_valid,
  input wire logic bpv_ready
);
  import lcr_pkg::*;

  // register copies, one set per channel
  logic [7:0] pattern_reg [NCH];
  logic [7:0] ja_reg [NCH];
  logic [7:0] tx_reg [NCH];
  logic [7:0] code_reg [NCH];
  lcr_ctrl_s [NCH-1:0] ch_ctrl_reg;
  logic [NCH-1:0] bpv_strobe_reg;
  logic [NCH-1:0] pin_sync1_reg;
  logic [NCH-1:0] pin_sync2_reg;
  logic [NCH-1:0] clk_sync1_reg;
  logic [NCH-1:0] clk_sync2_reg;
  logic [NCH-1:0] clk_prev_reg;
  logic [NCH-1:0] bpv_sampled_reg;
  logic [NCH-1:0] bpv_pending_reg;
  logic [NCH-1:0] bpv_pending_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ev_valid;
  logic ev_ready;
  logic [2:0] ev_chan;
  logic [2:0] fifo_data;
  logic fifo_valid;
  logic [2:0] out_chan_reg;
  logic out_valid_reg;

  // channel field of an address; upper nibble names the channel
  function automatic logic hit(input logic [7:0] a, input logic [3:0] off, input int ch);
    return (a[7:4] == 4'(ch)) && (a[3:0] == off);
  endfunction

  // host writes; only documented bits are stored, reserved bits stay zero
  always_ff @(posedge sys_clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
      begin
        pattern_reg[c] <= RST_REG;
        ja_reg[c] <= RST_REG;
        tx_reg[c] <= RST_REG;
        code_reg[c] <= RST_REG;
      end
      else if (reg_wr)
      begin
        if (hit(reg_addr, OFF_PATTERN, c))
          pattern_reg[c] <= reg_wdata & MASK_PATTERN;
        if (hit(reg_addr, OFF_JA_CFG, c))
          ja_reg[c] <= reg_wdata & MASK_JA_CFG;
        if (hit(reg_addr, OFF_TX_TEST_LOOP, c))
          tx_reg[c] <= reg_wdata;
        if (hit(reg_addr, OFF_CODING, c))
          code_reg[c] <= reg_wdata & MASK_CODING;
      end
    end
  end

  // read mux; unmapped offsets and channels answer zero
  always_comb
  begin
    rdata_next = 8'h00;
    for (int c = 0; c < NCH; c++)
    begin
      if (hit(reg_addr, OFF_PATTERN, c))
        rdata_next = pattern_reg[c];
      if (hit(reg_addr, OFF_JA_CFG, c))
        rdata_next = ja_reg[c];
      if (hit(reg_addr, OFF_TX_TEST_LOOP, c))
        rdata_next = tx_reg[c];
      if (hit(reg_addr, OFF_CODING, c))
        rdata_next = code_reg[c];
    end
  end

  // read data is held for exactly the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  // enable pin comes from a board pin, so two flops before use
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_sync1_reg <= '0;
      pin_sync2_reg <= '0;
    end
    else
    begin
      pin_sync1_reg <= {NCH{tx_power_pin}};
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // decode control words for the datapath
  always_ff @(posedge sys_clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
        ch_ctrl_reg[c] <= '0;
      else
      begin
        ch_ctrl_reg[c].tx_power <= tx_reg[c][POS_TX_EN] && pin_sync2_reg[c];
        ch_ctrl_reg[c].pattern_invert <= pattern_reg[c][POS_PATTERN_TYPE] && tx_reg[c][POS_INVERT];
        case (tx_reg[c][POS_DIAG_LO +: 3])
          3'h4: ch_ctrl_reg[c].pattern <= pattern_reg[c][POS_PATTERN_TYPE] ? 2'(lcr_pat_qrss)
                                                                           : 2'(lcr_pat_prbs);
          3'h5: ch_ctrl_reg[c].pattern <= 2'(lcr_pat_ones);
          default: ch_ctrl_reg[c].pattern <= 2'(lcr_pat_none); // reserved diagnostic select values send nothing
        endcase
        case (tx_reg[c][POS_LOOP_LO +: 3])
          3'h4: ch_ctrl_reg[c].loop <= 3'(lcr_loop_dual);
          3'h5: ch_ctrl_reg[c].loop <= 3'(lcr_loop_analog);
          3'h6: ch_ctrl_reg[c].loop <= 3'(lcr_loop_remote);
          3'h7: ch_ctrl_reg[c].loop <= 3'(lcr_loop_digital);
          default: ch_ctrl_reg[c].loop <= 3'(lcr_loop_none);
        endcase
        ch_ctrl_reg[c].ja_tx <= (ja_reg[c][POS_PATH_LO +: 2] == 2'h1);
        ch_ctrl_reg[c].ja_rx <= ja_reg[c][POS_PATH_LO + 1];
        if (!e1_mode)
          ch_ctrl_reg[c].ja_corner <= BW_T1;
        else
          ch_ctrl_reg[c].ja_corner <= ja_reg[c][POS_BW] ? BW_E1_NARROW : BW_E1_WIDE;
        ch_ctrl_reg[c].ja_depth <= ja_reg[c][POS_DEPTH] ? DEPTH_LONG : DEPTH_SHORT;
        ch_ctrl_reg[c].ja_latency <= ja_reg[c][POS_DEPTH] ? DEPTH_LONG[6:1] : DEPTH_SHORT[6:1];
        ch_ctrl_reg[c].ami <= single_rail && code_reg[c][POS_LINE_CODE];
        case (code_reg[c][POS_RES_LO +: 2])
          2'h1: ch_ctrl_reg[c].res_ohms <= RES_240;
          2'h2: ch_ctrl_reg[c].res_ohms <= RES_210;
          2'h3: ch_ctrl_reg[c].res_ohms <= RES_150;
          default: ch_ctrl_reg[c].res_ohms <= 8'h00;
        endcase
      end
    end
  end

  // transmit clocks are oversampled; sys_clk must run well above line rate
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clk_sync1_reg <= '0;
      clk_sync2_reg <= '0;
      clk_prev_reg <= '0;
    end
    else
    begin
      clk_sync1_reg <= tx_line_clock;
      clk_sync2_reg <= clk_sync1_reg;
      clk_prev_reg <= clk_sync2_reg;
    end
  end

  // violation bit sampled at each transmit clock rising edge; a 0-to-1 seen there arms one insertion
  always_comb
  begin
    bpv_pending_next = bpv_pending_reg;
    for (int c = 0; c < NCH; c++)
    begin
      if (ev_ready && ev_chan == 3'(c))
        bpv_pending_next[c] = 1'b0;
      if (clk_sync2_reg[c] && !clk_prev_reg[c] && code_reg[c][POS_BPV] && !bpv_sampled_reg[c])
        bpv_pending_next[c] = 1'b1; // set wins over the clear
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bpv_sampled_reg <= '0;
      bpv_pending_reg <= '0;
      bpv_strobe_reg <= '0;
    end
    else
    begin
      bpv_pending_reg <= bpv_pending_next;
      for (int c = 0; c < NCH; c++)
      begin
        if (clk_sync2_reg[c] && !clk_prev_reg[c])
          bpv_sampled_reg[c] <= code_reg[c][POS_BPV];
        bpv_strobe_reg[c] <= ev_valid && ev_ready && ev_chan == 3'(c);
      end
    end
  end

  // lowest pending channel is offered to the event fifo
  always_comb
  begin
    ev_valid = 1'b0;
    ev_chan = 3'h0;
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (bpv_pending_reg[c])
      begin
        ev_valid = 1'b1;
        ev_chan = 3'(c);
      end
    end
  end

  lcr_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(ev_chan),
    .in_valid(ev_valid),
    .in_ready(ev_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(!out_valid_reg)
  );

  // registered output stage; valid never waits for ready, so a stalled consumer still sees the event
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid_reg <= 1'b0;
      out_chan_reg <= 3'h0;
    end
    else if (out_valid_reg && bpv_ready)
      out_valid_reg <= 1'b0;
    else if (!out_valid_reg && fifo_valid)
    begin
      out_valid_reg <= 1'b1;
      out_chan_reg <= fifo_data;
    end
  end

  assign reg_rdata = rdata_reg;
  assign ch_ctrl = ch_ctrl_reg;
  assign bpv_strobe = bpv_strobe_reg;
  assign bpv_channel = out_chan_reg;
  assign bpv_valid = out_valid_reg;
endmodule // lcr_regs
`default_nettype wire

// ==== tb/lcr_regs_properties.sv ====
// assertion checker for the line control register bank
`timescale 1ns/100ps
`default_nettype none
module lcr_regs_properties
  import lcr_pkg::*;
#(
  parameter int NCH = lcr_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [lcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic e1_mode,
  input wire logic single_rail,
  input wire logic tx_power_pin,
  input wire logic [NCH-1:0] tx_line_clock,
  input wire lcr_pkg::lcr_ctrl_s [NCH-1:0] ch_ctrl,
  input wire logic [NCH-1:0] bpv_strobe,
  input wire logic [2:0] bpv_channel,
  input wire logic bpv_valid,
  input wire logic bpv_ready
);
  logic [NCH-1:0] pwr; // power state of every channel
  // gather the power bits so one check covers all channels
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      pwr[i] = ch_ctrl[i].tx_power;
  end
  // expected loopback code, written out independently of the design
  function automatic logic [2:0] loop_of(logic [2:0] c);
    return c[2] ? {1'b0, c[1:0]} + 3'h1 : 3'h0;
  endfunction
  // expected resistor value in ohms
  function automatic logic [7:0] res_of(logic [1:0] s);
    return s == 2'h0 ? 8'h00 : s == 2'h1 ? 8'hf0 : s == 2'h2 ? 8'hd2 : 8'h96;
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // pin dropped and stayed low long enough to reach the outputs
  sequence pin_gone_s;
    $fell(tx_power_pin) ##1 !tx_power_pin [*2];
  endsequence
  read_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  unmapped_read_a: assert property (reg_rd && reg_addr[3:0] > 4'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  corner_t1_a: assert property (!$past(rst) && !$past(e1_mode) |-> ch_ctrl[0].ja_corner == 7'h1e)
    else $error("t1 corner wrong");
  latency_half_a: assert property (!$past(rst) |-> ch_ctrl[1].ja_latency == ch_ctrl[1].ja_depth[6:1])
    else $error("latency not half depth");
  power_pin_off_a: assert property (pin_gone_s |=> pwr == '0)
    else $error("transmitter on with pin low");
  loop_decode_a: assert property (reg_wr && reg_addr == 8'h12 |=> ##1
    ch_ctrl[1].loop == loop_of($past(reg_wdata[2:0], 2)))
    else $error("loopback decode wrong");
  res_decode_a: assert property (reg_wr && reg_addr == 8'h13 |=> ##1
    ch_ctrl[1].res_ohms == res_of($past(reg_wdata[4:3], 2)))
    else $error("resistor decode wrong");
  pattern_ones_a: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata[6:4] == 3'h5 |=> ##1
    ch_ctrl[1].pattern == 2'h3)
    else $error("all ones pattern wrong");
  strobe_single_a: assert property ($rose(bpv_strobe[0]) |=> !bpv_strobe[0])
    else $error("violation strobe too long");
  event_hold_a: assert property (bpv_valid && !bpv_ready |=> bpv_valid && $stable(bpv_channel))
    else $error("event dropped while stalled");
endmodule // lcr_regs_properties
bind lcr_regs lcr_regs_properties #(.NCH(NCH)) lcr_regs_properties_i (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .e1_mode, .single_rail, .tx_power_pin, .tx_line_clock, .ch_ctrl, .bpv_strobe,
  .bpv_channel, .bpv_valid, .bpv_ready);
`default_nettype wire

// ==== tb/lcr_line_model.sv ====
// line side model: transmit line clocks and a violation event sink
`timescale 1ns/100ps
`default_nettype none
module lcr_line_model
  import lcr_pkg::*;
#(
  parameter int NCH = lcr_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall,
  output logic [NCH-1:0] tx_line_clock,
  input wire logic [2:0] bpv_channel,
  input wire logic bpv_valid,
  output logic bpv_ready,
  output logic [7:0] ev_count,
  output logic [NCH-1:0] ev_seen
);
  logic [7:0] div_reg; // line clock divider
  // free-running line clock at one eighth of the system rate, slow enough for the oversampler
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end
  assign tx_line_clock = {NCH{div_reg[2]}};
  assign bpv_ready = !stall; // stall models a slow consumer
  // count every violation taken and note its channel
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ev_count <= 8'h00;
      ev_seen <= '0;
    end
    else if (bpv_valid && bpv_ready)
    begin
      ev_count <= ev_count + 8'h01;
      ev_seen[bpv_channel] <= 1'b1;
    end
  end
endmodule // lcr_line_model
`default_nettype wire

// ==== tb/lcr_regs_tb_top.sv ====
// testbench for the line control register bank
`timescale 1ns/100ps
`default_nettype none
module lcr_regs_tb_top;
  import lcr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic e1_mode = 1'b0;
  logic single_rail = 1'b0;
  logic tx_power_pin = 1'b1;
  logic stall = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] tx_line_clock;
  lcr_ctrl_s [7:0] ch_ctrl;
  logic [7:0] bpv_strobe;
  logic [2:0] bpv_channel;
  logic bpv_valid;
  logic bpv_ready;
  logic [7:0] ev_count;
  logic [7:0] ev_seen;
  int bad_count = 0;
  int samples_checked = 0;
  int strobes = 0;
  always #12.5 sys_clk = ~sys_clk;
  // count violation strobes seen on any channel
  always @(posedge sys_clk)
    strobes <= strobes + $countones(bpv_strobe);
  lcr_regs lcr_regs_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e1_mode(e1_mode), .single_rail(single_rail),
    .tx_power_pin(tx_power_pin), .tx_line_clock(tx_line_clock), .ch_ctrl(ch_ctrl), .bpv_strobe(bpv_strobe),
    .bpv_channel(bpv_channel), .bpv_valid(bpv_valid), .bpv_ready(bpv_ready));
  lcr_line_model lcr_line_model_i (.sys_clk(sys_clk), .rst(rst), .stall(stall), .tx_line_clock(tx_line_clock),
    .bpv_channel(bpv_channel), .bpv_valid(bpv_valid), .bpv_ready(bpv_ready), .ev_count(ev_count),
    .ev_seen(ev_seen));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // let decoded controls land, one cycle after the register
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_regs;
    logic [7:0] v;
    logic [7:0] mask [4] = '{8'h80, 8'h0f, 8'hff, 8'h3c};
    for (int o = 0; o < 4; o++)
    begin
      rd(8'h70 | 8'(o), v);
      chk(v, 8'h00);
      wr(8'h30 | 8'(o), 8'hff);
      rd(8'h30 | 8'(o), v);
      chk(v, mask[o]);
      rd(8'h20 | 8'(o), v);
      chk(v, 8'h00);
    end
    rd(8'h3f, v);
    chk(v, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_ja;
    for (int m = 0; m < 32; m++)
    begin
      e1_mode <= m[4];
      wr(8'h11, 8'(m[3:0]));
      settle(2);
      chk(8'(ch_ctrl[1].ja_corner), m[4] ? (m[1] ? 8'h0f : 8'h64) : 8'h1e);
      chk(8'(ch_ctrl[1].ja_depth), m[0] ? 8'h40 : 8'h20);
      chk(8'(ch_ctrl[1].ja_latency), m[0] ? 8'h20 : 8'h10);
      chk(8'({ch_ctrl[1].ja_tx, ch_ctrl[1].ja_rx}), m[3] ? 8'h01 : (m[2] ? 8'h02 : 8'h00));
    end
    e1_mode <= 1'b0;
    $display("test_ja done");
  endtask
  task automatic test_tx;
    logic [7:0] pt [5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] tc [5] = '{8'hc0, 8'h40, 8'h40, 8'h50, 8'h30};
    logic [7:0] ex [5] = '{8'h05, 8'h01, 8'h02, 8'h03, 8'h00}; // invert bit above pattern code
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h12, 8'(i));
      settle(2);
      chk(8'(ch_ctrl[1].loop), i[2] ? 8'(i[1:0]) + 8'h01 : 8'h00);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h10, pt[i]);
      wr(8'h12, tc[i]);
      settle(2);
      chk(8'({ch_ctrl[1].pattern_invert, ch_ctrl[1].pattern}), ex[i]);
    end
    chk(8'(ch_ctrl[1].tx_power), 8'h00);
    wr(8'h12, 8'h08);
    settle(2);
    chk(8'(ch_ctrl[1].tx_power), 8'h01);
    tx_power_pin <= 1'b0;
    settle(5);
    chk(8'(ch_ctrl[1].tx_power), 8'h00);
    tx_power_pin <= 1'b1;
    settle(5);
    chk(8'(ch_ctrl[1].tx_power), 8'h01);
    $display("test_tx done");
  endtask
  task automatic test_code;
    logic [7:0] res [4] = '{8'h00, 8'hf0, 8'hd2, 8'h96};
    for (int k = 0; k < 16; k++)
    begin
      single_rail <= k[3];
      wr(8'h13, {2'h0, k[2], k[1:0], 3'h0});
      settle(2);
      chk(ch_ctrl[1].res_ohms, res[k[1:0]]);
      chk(8'(ch_ctrl[1].ami), 8'(k[2] & k[3]));
    end
    $display("test_code done");
  endtask
  task automatic test_bpv;
    logic [7:0] base;
    int sb;
    base = ev_count;
    sb = strobes;
    stall <= 1'b1;
    for (int c = 0; c < 8; c++)
      wr(8'(c * 16 + 3), 8'h00);
    settle(24);
    for (int c = 0; c < 8; c++)
      wr(8'(c * 16 + 3), 8'h04);
    settle(40);
    chk(8'(strobes - sb), 8'h08);
    chk(8'(bpv_valid), 8'h01);
    stall <= 1'b0;
    for (int n = 0; n < 200 && ev_count !== base + 8'h08; n++)
      @(posedge sys_clk);
    chk(ev_count - base, 8'h08);
    if (ev_count !== base + 8'h08)
      end_sim;
    chk(ev_seen, 8'hff);
    wr(8'h03, 8'h04);
    settle(40);
    chk(ev_count - base, 8'h08);
    $display("test_bpv done");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    test_regs;
    test_ja;
    test_tx;
    test_code;
    test_bpv;
    end_sim;
  end
endmodule // lcr_regs_tb_top
`default_nettype wire
